// ---- design/ldpl_top.sv ----
// Summary of operation
// - irq pending only reported when global gate bit 0 is set; resets to 0
// - read-only pending flag set while service needed; software then checks sources
// - pattern generator and detector work only in host mode
// - generator sends 2^23-1 sequence at E3, 2^15-1 otherwise
// - pattern enable turns on detector together with generator
// - violation output low while detector is locked and no error pulse is active
// - out of sync: lock-lost bit set and violation output high
// - rising edge of insert bit injects exactly one bit error
// - each error detected while locked pulses violation output high for half a receive clock
// - detected errors counted in a 16-bit counter while pattern mode on
// - reading a counter byte copies the other byte to capture, clears both
// - three loopbacks selected by pins in hardware mode, bits in host mode
// - far,near select: 00 normal, 01 analog, 10 remote, 11 digital
// - analog loop: own line output feeds receiver, line input ignored
// - digital loop: transmit clock and rails go to receive outputs, line quiet
// - remote loop: received data retransmitted on receive clock, still output
// - remote loop ignores terminal transmit clock and rails
// - all-ones send makes continuous AMI ones at transmit clock rate, except in digital loop where line stays quiet
// - two read-only identification bytes: device id and revision
`timescale 1ns/1ps
`default_nettype none
module ldpl_top
  import ldpl_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_host_mode,
  input  wire logic       i_far_loop_select,
  input  wire logic       i_near_loop_select,
  input  wire logic       i_all_ones_send,
  input  wire logic       i_terminal_tx_clock,
  input  wire logic       i_tx_pos_rail_in,
  input  wire logic       i_tx_neg_rail_in,
  input  wire logic       i_line_rx_plus,
  input  wire logic       i_line_rx_minus,
  input  wire logic       i_line_rx_clock,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_line_tx_plus,
  output logic            o_line_tx_minus,
  output logic            o_recovered_clock_out,
  output logic            o_rx_pos_rail_out,
  output logic            o_rx_neg_rail_violation_out
);

  typedef struct packed {
    logic [SY_W-1:0] sy1;
    logic [SY_W-1:0] sy2;
    logic [7:0]      chan_ctrl;
    logic [1:0]      own_ctrl;
    logic            irq_global_gate;
    logic            ins_prev;
    logic            ins_pend;
    logic            tck_q;
    logic            rck_q;
    logic [22:0]     gen;
    logic [22:0]     det;
    logic [5:0]      good_run;
    logic [2:0]      bad_run;
    logic            locked;
    logic            err_pulse;
    logic [15:0]     cnt;
    logic [7:0]      capture;
    logic            ami_neg;
    logic            tx_p;
    logic            tx_m;
    logic            rx_clk_o;
    logic            rx_p_o;
    logic            rx_n_o;
    logic [7:0]      rdata;
  } ldpl_state_t;

  ldpl_state_t s;
  ldpl_state_t next_s;

  // pattern feedback, rate selects the polynomial
  function automatic logic fb(input logic [22:0] x, input logic e3);
    fb = e3 ? (x[22] ^ x[17]) : (x[14] ^ x[13]);
  endfunction : fb

  logic host;
  logic far_sel;
  logic near_sel;
  logic ones_on;
  logic prbs_on;
  logic remote_lb;
  logic analog_lb;
  logic digital_lb;
  logic tck;
  logic rck;
  logic tck_rise;
  logic rck_rise;
  logic rck_fall;
  logic rx_src_p;
  logic rx_src_m;
  logic rx_bit;
  logic det_err;
  logic tx_bit;
  logic cnt_read;
  logic lock_lost;

  // mode decode from synchronised pins or host bits
  always_comb begin
    host       = s.sy2[SY_HOST];
    far_sel    = host ? s.chan_ctrl[CC_FAR]  : s.sy2[SY_FAR];
    near_sel   = host ? s.chan_ctrl[CC_NEAR] : s.sy2[SY_NEAR];
    ones_on    = host ? s.own_ctrl[OC_ALL_ONES] : s.sy2[SY_ONES];
    prbs_on    = host & s.chan_ctrl[CC_PATTERN];
    remote_lb  = far_sel & ~near_sel;
    analog_lb  = ~far_sel & near_sel;
    digital_lb = far_sel & near_sel;
    tck        = remote_lb ? s.sy2[SY_RECOVERED_CLOCK_OUT] : s.sy2[SY_TERMINAL_TX_CLOCK];
    rck        = near_sel ? s.sy2[SY_TERMINAL_TX_CLOCK] : s.sy2[SY_RECOVERED_CLOCK_OUT];
    tck_rise   = tck & ~s.tck_q;
    rck_rise   = rck & ~s.rck_q;
    rck_fall   = ~rck & s.rck_q;
    lock_lost  = prbs_on & ~s.locked;
    cnt_read   = i_reg_rd & ((i_reg_addr == ADDR_CNT_HIGH) | (i_reg_addr == ADDR_CNT_LOW));
  end

  // receive source: own line output, terminal rails or line input
  always_comb begin
    if (analog_lb) begin
      rx_src_p = s.tx_p;
      rx_src_m = s.tx_m;
    end else if (digital_lb) begin
      rx_src_p = s.sy2[SY_TPOS];
      rx_src_m = s.sy2[SY_TNEG];
    end else begin
      rx_src_p = s.sy2[SY_RXP];
      rx_src_m = s.sy2[SY_RXM];
    end
    rx_bit  = rx_src_p | rx_src_m;
    det_err = rx_bit != fb(s.det, s.chan_ctrl[CC_RATE_E3]);
    tx_bit  = fb(s.gen, s.chan_ctrl[CC_RATE_E3]) ^ s.ins_pend;
  end

  // next state
  always_comb begin
    next_s     = s;
    next_s.sy1 = {i_line_rx_clock, i_line_rx_minus, i_line_rx_plus, i_tx_neg_rail_in,
                  i_tx_pos_rail_in, i_terminal_tx_clock, i_all_ones_send,
                  i_near_loop_select, i_far_loop_select, i_host_mode};
    next_s.sy2 = s.sy1;
    next_s.tck_q = tck;
    next_s.rck_q = rck;
    // register writes
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_CHAN_CTRL: next_s.chan_ctrl = i_reg_wdata;
        ADDR_OWN_CTRL:  next_s.own_ctrl = i_reg_wdata[1:0];
        ADDR_IRQ_GATE:  next_s.irq_global_gate = i_reg_wdata[0];
        default: ;
      endcase
    end
    // insert request history for 0 to 1 detection
    next_s.ins_prev = s.own_ctrl[OC_INSERT];
    // transmit side
    if (tck_rise) begin
      if (digital_lb) begin
        next_s.tx_p = 1'b0;
        next_s.tx_m = 1'b0;
      end else if (ones_on) begin
        next_s.tx_p    = ~s.ami_neg;
        next_s.tx_m    = s.ami_neg;
        next_s.ami_neg = ~s.ami_neg;
      end else if (prbs_on) begin
        next_s.gen      = {s.gen[21:0], fb(s.gen, s.chan_ctrl[CC_RATE_E3])};
        next_s.tx_p     = tx_bit & ~s.ami_neg;
        next_s.tx_m     = tx_bit & s.ami_neg;
        next_s.ami_neg  = s.ami_neg ^ tx_bit;
        next_s.ins_pend = 1'b0;
      end else if (remote_lb) begin
        next_s.tx_p = s.sy2[SY_RXP];
        next_s.tx_m = s.sy2[SY_RXM];
      end else begin
        next_s.tx_p = s.sy2[SY_TPOS];
        next_s.tx_m = s.sy2[SY_TNEG];
      end
    end
    // insert request armed by a 0 to 1 transition; set after the send so it wins a same-cycle clear
    if (prbs_on && s.own_ctrl[OC_INSERT] && !s.ins_prev) begin
      next_s.ins_pend = 1'b1;
    end
    // receive side and detector
    if (rck_rise) begin
      next_s.rx_clk_o = 1'b1;
      next_s.rx_p_o   = rx_src_p;
      next_s.rx_n_o   = rx_src_m;
      if (prbs_on) begin
        next_s.det = {s.det[21:0], rx_bit};
        if (det_err) begin
          next_s.good_run  = '0;
          next_s.err_pulse = s.locked;
          if (s.bad_run == LOSS_BAD_RUN - 3'h1) begin
            next_s.locked  = 1'b0;
            next_s.bad_run = '0;
          end else begin
            next_s.bad_run = s.bad_run + 3'h1;
          end
        end else begin
          next_s.bad_run = '0;
          if (s.good_run == LOCK_GOOD_RUN - 6'h01) begin
            next_s.locked = 1'b1;
          end else begin
            next_s.good_run = s.good_run + 6'h01;
          end
        end
      end
    end
    if (rck_fall) begin
      next_s.rx_clk_o  = 1'b0;
      next_s.err_pulse = 1'b0;
    end
    if (!prbs_on) begin
      next_s.locked    = 1'b0;
      next_s.good_run  = '0;
      next_s.bad_run   = '0;
      next_s.err_pulse = 1'b0;
      next_s.ins_pend  = 1'b0;   // no stale insert once pattern mode comes back
    end else begin
      next_s.rx_n_o = ~next_s.locked | next_s.err_pulse;
    end
    // error counter with read capture; an error in the read cycle survives
    if (cnt_read) begin
      next_s.capture = (i_reg_addr == ADDR_CNT_HIGH) ? s.cnt[7:0] : s.cnt[15:8];
      next_s.cnt     = '0;
    end
    if (prbs_on && rck_rise && det_err && (cnt_read || s.cnt != CNT_MAX)) begin
      next_s.cnt = next_s.cnt + 16'h0001;
    end
    // read data
    next_s.rdata = BYTE_ZERO;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_OWN_STATUS:  next_s.rdata = {7'h00, lock_lost};
        ADDR_OWN_CTRL:    next_s.rdata = {6'h00, s.own_ctrl};
        ADDR_CHAN_CTRL:   next_s.rdata = s.chan_ctrl;
        ADDR_IRQ_GATE:    next_s.rdata = {7'h00, s.irq_global_gate};
        ADDR_IRQ_PENDING: next_s.rdata = {7'h00, s.irq_global_gate & lock_lost};
        ADDR_CNT_HIGH:    next_s.rdata = s.cnt[15:8];
        ADDR_CNT_LOW:     next_s.rdata = s.cnt[7:0];
        ADDR_CNT_CAPTURE: next_s.rdata = s.capture;
        ADDR_DEVICE_ID:   next_s.rdata = DEVICE_ID_VALUE;
        ADDR_DEVICE_REV:  next_s.rdata = DEVICE_REV_VALUE;
        default:          next_s.rdata = BYTE_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s     <= '0;
      s.gen <= PRBS_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign o_reg_rdata                 = s.rdata;
  assign o_line_tx_plus              = s.tx_p;
  assign o_line_tx_minus             = s.tx_m;
  assign o_recovered_clock_out       = s.rx_clk_o;
  assign o_rx_pos_rail_out           = s.rx_p_o;
  assign o_rx_neg_rail_violation_out = s.rx_n_o;

  // checks
  chk_pending_gated: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && i_reg_addr == ADDR_IRQ_PENDING && !s.irq_global_gate) |=> o_reg_rdata == 8'h00)
    else $error("pending flag seen with gate off");
  chk_pending_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && i_reg_addr == ADDR_IRQ_PENDING && s.irq_global_gate && lock_lost)
    |=> o_reg_rdata[0])
    else $error("pending flag missing");
  chk_no_host_lock: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !host |=> !s.locked)
    else $error("detector active outside host mode");
  chk_lock_low: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (prbs_on && $past(prbs_on) && s.locked && !s.err_pulse) |-> !o_rx_neg_rail_violation_out)
    else $error("violation high while locked");
  chk_unlock_high: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (prbs_on && $past(prbs_on) && !s.locked) |-> o_rx_neg_rail_violation_out)
    else $error("violation low while out of sync");
  chk_err_half: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.err_pulse |-> o_recovered_clock_out && o_rx_neg_rail_violation_out)
    else $error("error pulse outside high clock half");
  chk_count_err: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (prbs_on && rck_rise && det_err && !cnt_read && s.cnt != CNT_MAX)
    |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("error not counted");
  chk_read_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_rd && i_reg_addr == ADDR_CNT_HIGH)
    |=> s.capture == $past(s.cnt[7:0]) && s.cnt <= 16'h0001)
    else $error("counter read did not capture and clear");
  chk_capture_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !cnt_read |=> $stable(s.capture))
    else $error("capture changed without a counter read");
  chk_digital_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (digital_lb && tck_rise) |=> !o_line_tx_plus && !o_line_tx_minus)
    else $error("line driven in digital loop");

endmodule : ldpl_top
`default_nettype wire

// ---- design/ldpl_pkg.sv ----
package ldpl_pkg;
  // register map
  localparam logic [7:0] ADDR_OWN_STATUS  = 8'h05;
  localparam logic [7:0] ADDR_OWN_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_CHAN_CTRL   = 8'h06;
  localparam logic [7:0] ADDR_IRQ_GATE    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_PENDING = 8'h21;
  localparam logic [7:0] ADDR_CNT_HIGH    = 8'h30;
  localparam logic [7:0] ADDR_CNT_LOW     = 8'h31;
  localparam logic [7:0] ADDR_CNT_CAPTURE = 8'h38;
  localparam logic [7:0] ADDR_DEVICE_ID   = 8'h3e;
  localparam logic [7:0] ADDR_DEVICE_REV  = 8'h3f;
  // identity values, arbitrary
  localparam logic [7:0] DEVICE_ID_VALUE  = 8'h5a;
  localparam logic [7:0] DEVICE_REV_VALUE = 8'h0c;
  // channel control field positions
  localparam int CC_RATE_E3 = 2;
  localparam int CC_NEAR    = 3;
  localparam int CC_FAR     = 4;
  localparam int CC_PATTERN = 5;
  // own control field positions
  localparam int OC_INSERT   = 0;
  localparam int OC_ALL_ONES = 1;
  // synchroniser bit positions
  localparam int SY_HOST  = 0;
  localparam int SY_FAR   = 1;
  localparam int SY_NEAR  = 2;
  localparam int SY_ONES  = 3;
  localparam int SY_TERMINAL_TX_CLOCK = 4;
  localparam int SY_TPOS  = 5;
  localparam int SY_TNEG  = 6;
  localparam int SY_RXP   = 7;
  localparam int SY_RXM   = 8;
  localparam int SY_RECOVERED_CLOCK_OUT = 9;
  localparam int SY_W     = 10;
  // pattern detector lock thresholds
  localparam logic [5:0]  LOCK_GOOD_RUN = 6'h20;
  localparam logic [2:0]  LOSS_BAD_RUN  = 3'h4;
  localparam logic [22:0] PRBS_SEED     = 23'h00_0001;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage : ldpl_pkg

// ---- test/ldpl_framer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldpl_framer_model (
  input  wire logic i_run,
  input  wire logic i_pos,
  input  wire logic i_neg,
  output logic      o_clk,
  output logic      o_pos,
  output logic      o_neg
);
  // 200 ns transmit clock, offset from the system clock; stands low while stopped
  initial begin
    o_clk = 1'b0;
    o_pos = 1'b0;
    o_neg = 1'b0;
    #7;
    forever begin
      #100;
      o_clk = i_run ? ~o_clk : 1'b0;
    end
  end
  // rails launched on the falling edge so they are steady at the sampling rise
  always @(negedge o_clk) begin
    o_pos <= i_pos;
    o_neg <= i_neg;
  end
endmodule : ldpl_framer_model
`default_nettype wire

// ---- test/line_diag_prbs_loopback_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_diag_prbs_loopback_tb;
  import ldpl_pkg::*;
  logic clk = 0, nrst = 0, host = 1, far = 0, near = 0, ones = 0;
  logic rx_p = 0, rx_m = 0, rx_on = 1, rx_clk = 0, run = 1, fpos = 0, fneg = 0;
  logic wr = 0, rd = 0, tck, tpos, tneg, txp, txm, rclk, rxpo, viol, viol_d = 0;
  logic [7:0]  addr = 0, wdata = 0, rdata, v;
  logic [15:0] n_pulse = 0, wcnt = 0, last_w = 0, n_txp = 0, n_txm = 0, n_both = 0, n_rclk = 0;
  logic [15:0] s0, s1, s2;
  logic        txp_d = 0, txm_d = 0, rclk_d = 0;
  int          n_fail = 0, n_compared = 0;
  initial forever #12.5 clk = ~clk;
  // recovered line clock, unrelated in phase, stopped when rx_on is low
  initial begin
    #61;
    forever begin
      #100;
      rx_clk = rx_on ? ~rx_clk : 1'b0;
    end
  end
  ldpl_framer_model u_ldpl_framer_model (.i_run(run), .i_pos(fpos), .i_neg(fneg), .o_clk(tck),
    .o_pos(tpos), .o_neg(tneg));
  ldpl_top u_ldpl_top (.i_clk_sys(clk), .i_nrst(nrst), .i_host_mode(host),
    .i_far_loop_select(far), .i_near_loop_select(near), .i_all_ones_send(ones),
    .i_terminal_tx_clock(tck), .i_tx_pos_rail_in(tpos), .i_tx_neg_rail_in(tneg),
    .i_line_rx_plus(rx_p), .i_line_rx_minus(rx_m), .i_line_rx_clock(rx_clk),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_line_tx_plus(txp), .o_line_tx_minus(txm), .o_recovered_clock_out(rclk),
    .o_rx_pos_rail_out(rxpo), .o_rx_neg_rail_violation_out(viol));
  // edge counters and violation pulse width monitor
  always @(posedge clk) begin
    viol_d <= viol;
    txp_d  <= txp;
    txm_d  <= txm;
    rclk_d <= rclk;
    if (viol && !viol_d) n_pulse <= n_pulse + 1;
    if (viol) wcnt <= wcnt + 1;
    else if (viol_d) begin
      last_w <= wcnt;
      wcnt   <= 0;
    end
    if (txp && !txp_d) n_txp <= n_txp + 1;
    if (txm && !txm_d) n_txm <= n_txm + 1;
    if (txp && txm) n_both <= n_both + 1;
    if (rclk && !rclk_d) n_rclk <= n_rclk + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("n_compared=%0d n_fail=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rreg
  task automatic wait_viol(input logic val, input int bound);
    for (int i = 0; i < bound && viol !== val; i++) @(posedge clk);
    if (viol !== val) begin
      check(viol, val);
      report_and_stop();
    end
  endtask : wait_viol
  task automatic t_regs();
    rreg(ADDR_IRQ_GATE, v); check(v, 0);
    rreg(ADDR_IRQ_PENDING, v); check(v, 0);
    wreg(ADDR_DEVICE_ID, 8'hff);
    rreg(ADDR_DEVICE_ID, v); check(v, DEVICE_ID_VALUE);
    rreg(ADDR_DEVICE_REV, v); check(v, DEVICE_REV_VALUE);
    wreg(ADDR_IRQ_PENDING, 8'hff);
    rreg(ADDR_IRQ_PENDING, v); check(v, 0);
    wreg(ADDR_IRQ_GATE, 8'h01);
    rreg(ADDR_IRQ_GATE, v); check(v, 1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_prbs();
    // long sequence rate first, then pattern off, then the short sequence
    wreg(ADDR_CHAN_CTRL, 8'h2c);
    wait_viol(1, 400);
    wait_viol(0, 20000);
    wreg(ADDR_CHAN_CTRL, 8'h00);
    repeat (40) @(posedge clk);
    check(viol, 0);
    wreg(ADDR_CHAN_CTRL, 8'h28);
    wait_viol(1, 400);
    wait_viol(0, 20000);
    rreg(ADDR_OWN_STATUS, v); check(v, 0);
    rreg(ADDR_IRQ_PENDING, v); check(v, 0);
    rreg(ADDR_CNT_HIGH, v);
    s0 = n_pulse;
    wreg(ADDR_OWN_CTRL, 8'h00);
    wreg(ADDR_OWN_CTRL, 8'h01);
    repeat (600) @(posedge clk);
    s1 = n_pulse - s0;
    check(s1 != 0, 1);
    check(last_w, 4);
    rreg(ADDR_CNT_HIGH, v); check(v, 0);
    rreg(ADDR_CNT_CAPTURE, v); check(v, s1[7:0]);
    rreg(ADDR_CNT_CAPTURE, v); check(v, s1[7:0]);
    rreg(ADDR_CNT_LOW, v); check(v, 0);
    wreg(ADDR_OWN_CTRL, 8'h01);
    repeat (600) @(posedge clk);
    check(n_pulse - s0, s1);
    $display("test prbs done");
  endtask : t_prbs
  task automatic t_sync_loss();
    rx_p <= 1;
    wreg(ADDR_CHAN_CTRL, 8'h20);
    wait_viol(1, 2000);
    // first rise may be an error pulse while still locked; let the loss settle
    repeat (400) @(posedge clk);
    check(viol, 1);
    rreg(ADDR_OWN_STATUS, v); check(v, 1);
    rreg(ADDR_IRQ_PENDING, v); check(v, 1);
    wreg(ADDR_IRQ_GATE, 8'h00);
    rreg(ADDR_IRQ_PENDING, v); check(v, 0);
    host <= 0;
    rx_p <= 0;
    repeat (60) @(posedge clk);
    check(viol, 0);
    $display("test sync loss done");
  endtask : t_sync_loss
  task automatic loop_case(input logic f, n, fp, rp, ron, fr, etx, erx);
    @(posedge clk);
    far <= f; near <= n; fpos <= fp; rx_p <= rp; rx_on <= ron; run <= fr;
    repeat (100) @(posedge clk);
    s0 = n_rclk;
    repeat (40) @(posedge clk);
    check(txp, etx);
    check(rxpo, erx);
    check(n_rclk != s0, 1);
  endtask : loop_case
  task automatic t_loops();
    loop_case(0, 0, 0, 1, 1, 1, 0, 1);
    loop_case(1, 0, 0, 1, 1, 0, 1, 1);
    loop_case(0, 1, 1, 0, 1, 1, 1, 1);
    loop_case(1, 1, 1, 0, 0, 1, 0, 1);
    $display("test loops done");
  endtask : t_loops
  task automatic t_ones();
    @(posedge clk);
    far <= 0; near <= 0; fpos <= 0; rx_on <= 1;
    for (int m = 0; m < 2; m++) begin
      if (m == 0) ones <= 1;
      else begin
        ones <= 0;
        host <= 1;
        wreg(ADDR_CHAN_CTRL, 8'h00);
        wreg(ADDR_OWN_CTRL, 8'h02);
      end
      repeat (60) @(posedge clk);
      s0 = n_txp; s1 = n_txm; s2 = n_both;
      repeat (200) @(posedge clk);
      check(n_txp != s0, 1);
      check(n_txm != s1, 1);
      check(n_both - s2, 0);
    end
    $display("test all ones done");
  endtask : t_ones
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    t_regs();
    t_prbs();
    t_sync_loss();
    t_loops();
    t_ones();
    report_and_stop();
  end
endmodule : line_diag_prbs_loopback_tb
`default_nettype wire
